// [shared/sbh_pkg.sv]
// Constants and types for the serial boot host controller.
// Assumes an 8-bit serial byte channel; bit framing is done elsewhere.
package sbh_pkg;
   localparam logic [7:0] CH_CR = 8'h0D;
   localparam logic [7:0] CH_LF = 8'h0A;
   localparam logic [7:0] CH_SP = 8'h20;
   localparam logic [7:0] CH_ZERO = 8'h30;
   localparam logic [7:0] CH_NINE = 8'h39;
   localparam logic [7:0] CH_READ = 8'h52;
   localparam logic [7:0] CH_PREP = 8'h50;
   localparam logic [7:0] CH_O = 8'h4F;
   localparam logic [7:0] CH_K = 8'h4B;
   localparam logic [7:0] CH_E = 8'h45;
   localparam logic [7:0] CH_S = 8'h53;
   localparam logic [7:0] CH_N = 8'h4E;
   localparam logic [7:0] CH_D = 8'h44;
   localparam logic [4:0] GRP_LINES = 5'h14;
   localparam logic [6:0] LINE_MAX_CHARS = 7'h3D;
   localparam logic [5:0] LINE_MAX_BYTES = 6'h2D;
   localparam logic [3:0] OK_LAST = 4'h3;
   localparam logic [3:0] RETRANSMIT_REQUEST_LAST = 4'h7;
   localparam logic [3:0] DEC_TOP_DIGIT = 4'h9;
   localparam logic [31:0] CODE_SUCCESS = 32'h0000_0000;
   // Results decided by the host itself, before or instead of the device
   localparam logic [2:0] LOC_NONE = 3'h0;
   localparam logic [2:0] LOC_ALIGN = 3'h1;
   localparam logic [2:0] LOC_COUNT = 3'h2;
   localparam logic [2:0] LOC_SECTOR = 3'h3;
   localparam logic [2:0] LOC_FORMAT = 3'h4;
   typedef enum logic [11:0] {
      S_IDLE  = 12'b0000_0000_0001,
      S_LETTER = 12'b0000_0000_0010,
      S_NUM_A = 12'b0000_0000_0100,
      S_SPACE = 12'b0000_0000_1000,
      S_NUM_B = 12'b0000_0001_0000,
      S_CR    = 12'b0000_0010_0000,
      S_LF    = 12'b0000_0100_0000,
      S_CODE  = 12'b0000_1000_0000,
      S_LINE  = 12'b0001_0000_0000,
      S_SUM   = 12'b0010_0000_0000,
      S_REPLY = 12'b0100_0000_0000
   } sbh_state_t;
endpackage : sbh_pkg

// [src/sbh_dec_tx.sv]
// Emits a 32-bit value as ASCII decimal digits, no leading zeros.
// Assumes the consumer takes one digit per valid/ready handshake.
`timescale 1ns/100ps
`default_nettype none
module sbh_dec_tx
   import sbh_pkg::*;
(
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic rst_i,
   // Value in
   input wire logic start_i,
   input wire logic [31:0] value_i,
   // Digit out
   output logic [7:0] char_o,
   output logic valid_o,
   output logic last_o,
   input wire logic ready_i
);
   logic [31:0] val_q;
   logic [3:0] pos_q;
   logic [3:0] dig_q;
   logic busy_q;
   logic lead_q;

   function automatic logic [31:0] pow10(input logic [3:0] p);
      logic [31:0] r;
      r = 32'h0000_0001;
      for (int i = 0; i < 9; i++) begin
         if (i < int'(p)) r = r * 32'h0000_000A;
      end
      return r;
   endfunction : pow10

   // Repeated subtraction: slow but tiny, and the serial link is slower
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         val_q <= 32'h0000_0000;
         pos_q <= 4'h0;
         dig_q <= 4'h0;
         busy_q <= 1'b0;
         lead_q <= 1'b0;
         char_o <= 8'h00;
         valid_o <= 1'b0;
         last_o <= 1'b0;
      end else if (start_i) begin
         val_q <= value_i;
         pos_q <= DEC_TOP_DIGIT;
         dig_q <= 4'h0;
         busy_q <= 1'b1;
         lead_q <= 1'b0;
         valid_o <= 1'b0;
         last_o <= 1'b0;
      end else if (valid_o) begin
         if (ready_i) begin
            valid_o <= 1'b0;
            if (last_o) busy_q <= 1'b0;
         end
      end else if (busy_q) begin
         if (val_q >= pow10(pos_q)) begin
            val_q <= val_q - pow10(pos_q);
            dig_q <= dig_q + 4'h1;
         end else begin
            if (dig_q != 4'h0 || lead_q || pos_q == 4'h0) begin
               char_o <= CH_ZERO + {4'h0, dig_q};
               valid_o <= 1'b1;
               last_o <= (pos_q == 4'h0);
               lead_q <= 1'b1;
            end
            dig_q <= 4'h0;
            if (pos_q != 4'h0) pos_q <= pos_q - 4'h1;
         end
      end
   end
endmodule : sbh_dec_tx
`default_nettype wire

// [src/sbh_host.sv]
// Host controller for the serial boot loader: memory read and sector prepare.
// Assumes a byte channel to the device; framing and baud are handled outside.
// Summary of operation
// (RL1) After success code, read data arrives as text-encoded lines.
// (RL2) A checksum line follows every 20 encoded data lines.
// (RL3) Checksum is raw byte sum, restarted after each 20-line group.
// (RL4) An encoded line holds at most 61 characters, 45 data bytes.
// (RL5) A shorter final group carries a checksum of only its bytes.
// (RL6) Host sums decoded bytes and compares after each group.
// (RL7) On match host answers OK, CR, LF.
// (RL8) On mismatch host answers the retransmit request, CR, LF.
// (RL9) Device then resends the failed group's data.
// (RL10) Read start address must be word aligned, else alignment error.
// (RL11) Read byte count must be a multiple of 4, else count error.
// (RL12) Reads may target on-chip RAM or flash.
// (RL13) With read protection on, device refuses reads with protection code.
// (RL14) Read request: letter, decimal address, decimal count, CR LF.
// (RL15) Flash write or erase needs a prior prepare of the sectors.
// (RL16) End sector must not be below start sector.
// (RL17) Host prepares sectors before any copy or erase command.
// (RL18) A finished copy or erase leaves those sectors unprepared again.
// (RL19) The boot block sector can never be prepared.
// (RL20) Equal start and end sector prepares one sector.
// (RL21) Unmapped, bad parameter and busy cases report their own codes.
// (RL22) Device echoes every received character while echo is on.
`timescale 1ns/100ps
`default_nettype none
module sbh_host
   import sbh_pkg::*;
(
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic rst_i,
   // User command
   input wire logic cmd_valid_i,
   input wire logic cmd_read_i,
   input wire logic [31:0] addr_i,
   input wire logic [31:0] count_i,
   input wire logic [7:0] sec_first_i,
   input wire logic [7:0] sec_last_i,
   input wire logic echo_on_i,
   input wire logic flash_op_done_i,
   // Serial byte channel
   output logic [7:0] tx_data_o,
   output logic tx_valid_o,
   input wire logic tx_ready_i,
   input wire logic [7:0] rx_data_i,
   input wire logic rx_valid_i,
   // Results
   output logic busy_o,
   output logic done_o,
   output logic [31:0] result_code_o,
   output logic [2:0] result_local_o,
   output logic [23:0] rd_data_o,
   output logic [1:0] rd_count_o,
   output logic [31:0] rd_offset_o,
   output logic rd_valid_o,
   output logic rd_rewind_o,
   output logic sectors_ready_o
);
   sbh_state_t state_q, state_d;
   logic read_q;
   logic [31:0] addr_q, count_q, num_q, sum_q, bytes_q, grp_q;
   logic [7:0] first_q, last_q;
   logic [6:0] echo_q, col_q;
   logic [4:0] lines_q;
   logic [5:0] left_q;
   logic [1:0] quad_q;
   logic [17:0] acc_q;
   logic retransmit_request_q;
   logic fld_q;
   logic [3:0] rep_q;
   logic [7:0] dec_char;
   logic dec_valid, dec_last, dec_start, dec_ready;
   logic [31:0] dec_value;
   logic tx_free, tx_load, tx_sent, rx_take, rx_echo;
   logic [7:0] tx_char, c;
   logic finish;
   logic [31:0] fin_code;
   logic [2:0] fin_local;
   logic is_lf, is_digit, quad_done, line_bad;
   logic [23:0] word;
   logic [1:0] nb;

   function automatic logic [5:0] uu6(input logic [7:0] ch);
      return {~ch[5], ch[4:0]};
   endfunction : uu6

   function automatic logic [31:0] dec_acc(input logic [31:0] v, input logic [7:0] ch);
      return 32'(v * 32'h0000_000A) + {28'h000_0000, ch[3:0]};
   endfunction : dec_acc

   function automatic logic [7:0] reply_char(input logic rs, input logic [3:0] i);
      logic [7:0] r;
      r = CH_LF;
      if (rs) begin
         unique case (i)
            4'h0: r = CH_READ;
            4'h1, 4'h3: r = CH_E;
            4'h2: r = CH_S;
            4'h4: r = CH_N;
            4'h5: r = CH_D;
            4'h6: r = CH_CR;
            default: r = CH_LF;
         endcase
      end else begin
         unique case (i)
            4'h0: r = CH_O;
            4'h1: r = CH_K;
            4'h2: r = CH_CR;
            default: r = CH_LF;
         endcase
      end
      return r;
   endfunction : reply_char

   sbh_dec_tx u_dec (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .start_i(dec_start),
      .value_i(dec_value),
      .char_o(dec_char),
      .valid_o(dec_valid),
      .last_o(dec_last),
      .ready_i(dec_ready)
   );

   assign tx_free = !tx_valid_o || tx_ready_i;
   assign tx_sent = tx_valid_o && tx_ready_i;
   // Echoed bytes are owed one per sent byte and swallowed first
   assign rx_echo = rx_valid_i && echo_on_i && echo_q != 7'h00; // RL22
   assign rx_take = rx_valid_i && !rx_echo && rx_data_i != CH_CR;
   assign c = rx_data_i;
   assign is_lf = (c == CH_LF);
   assign is_digit = (c >= CH_ZERO) && (c <= CH_NINE);
   assign quad_done = rx_take && state_q == S_LINE && !is_lf && col_q != 7'h00 && quad_q == 2'h3;
   assign word = {acc_q, uu6(c)};
   assign nb = (left_q >= 6'h03) ? 2'h3 : left_q[1:0];
   assign line_bad = (col_q == 7'h00) ? (uu6(c) > LINE_MAX_BYTES) : (col_q >= LINE_MAX_CHARS); // RL4

   always_comb begin
      state_d = state_q;
      tx_load = 1'b0;
      tx_char = CH_LF;
      dec_start = 1'b0;
      dec_value = read_q ? addr_q : {24'h00_0000, first_q};
      dec_ready = 1'b0;
      finish = 1'b0;
      fin_code = CODE_SUCCESS;
      fin_local = LOC_NONE;
      unique case (state_q)
         S_IDLE: begin
            if (cmd_valid_i) begin
               state_d = S_LETTER;
               if (cmd_read_i && addr_i[1:0] != 2'h0) begin
                  fin_local = LOC_ALIGN; // RL10
               end else if (cmd_read_i && count_i[1:0] != 2'h0) begin
                  fin_local = LOC_COUNT; // RL11
               end else if (!cmd_read_i && sec_last_i < sec_first_i) begin
                  fin_local = LOC_SECTOR; // RL16 RL20
               end
               if (fin_local != LOC_NONE) begin
                  finish = 1'b1;
                  state_d = S_IDLE;
               end
            end
         end
         S_LETTER: if (tx_free) begin
            tx_load = 1'b1;
            tx_char = read_q ? CH_READ : CH_PREP; // RL14
            state_d = S_SPACE;
         end
         S_NUM_A, S_NUM_B: begin
            dec_ready = tx_free;
            if (dec_valid && tx_free) begin
               tx_load = 1'b1;
               tx_char = dec_char;
               if (dec_last) state_d = (state_q == S_NUM_A) ? S_SPACE : S_CR;
            end
         end
         S_SPACE: if (tx_free) begin
            tx_load = 1'b1;
            tx_char = CH_SP; // RL14
            dec_start = 1'b1;
            // One separator state serves both numbers
            if (fld_q) dec_value = read_q ? count_q : {24'h00_0000, last_q};
            state_d = fld_q ? S_NUM_B : S_NUM_A;
         end
         S_CR: if (tx_free) begin
            tx_load = 1'b1;
            tx_char = CH_CR;
            state_d = S_LF;
         end
         S_LF: if (tx_free) begin
            tx_load = 1'b1;
            tx_char = CH_LF;
            state_d = S_CODE;
         end
         S_CODE: if (rx_take && is_lf) begin
            // Any failure code (protection, unmapped, parameter, busy) ends here
            if (num_q != CODE_SUCCESS || !read_q || count_q == 32'h0000_0000) begin // RL13 RL21
               finish = 1'b1;
               fin_code = num_q;
               state_d = S_IDLE;
            end else begin
               state_d = S_LINE; // RL1 RL12
            end
         end
         S_LINE: if (rx_take) begin
            if (is_lf) begin
               if (lines_q + 5'h01 == GRP_LINES || bytes_q == count_q) state_d = S_SUM; // RL2 RL5
            end else if (line_bad) begin
               finish = 1'b1;
               fin_local = LOC_FORMAT;
               state_d = S_IDLE;
            end
         end
         S_SUM: if (rx_take && is_lf) state_d = S_REPLY; // RL6
         S_REPLY: if (tx_free) begin
            tx_load = 1'b1;
            tx_char = reply_char(retransmit_request_q, rep_q); // RL7 RL8
            if (rep_q == (retransmit_request_q ? RETRANSMIT_REQUEST_LAST : OK_LAST)) begin
               if (!retransmit_request_q && bytes_q == count_q) begin
                  finish = 1'b1;
                  state_d = S_IDLE;
               end else begin
                  state_d = S_LINE; // RL9
               end
            end
         end
         default: state_d = S_IDLE;
      endcase
   end

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_q <= S_IDLE;
         busy_o <= 1'b0;
      end else begin
         state_q <= state_d;
         busy_o <= (state_d != S_IDLE);
      end
   end

   // Command capture
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         read_q <= 1'b0;
         addr_q <= 32'h0000_0000;
         count_q <= 32'h0000_0000;
         first_q <= 8'h00;
         last_q <= 8'h00;
         fld_q <= 1'b0;
      end else if (state_q == S_IDLE && cmd_valid_i) begin
         read_q <= cmd_read_i;
         addr_q <= addr_i;
         count_q <= count_i;
         first_q <= sec_first_i;
         last_q <= sec_last_i;
         fld_q <= 1'b0;
      end else if (state_q == S_NUM_A) begin
         fld_q <= 1'b1;
      end
   end

   // Transmit register and echo debt
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         tx_valid_o <= 1'b0;
         tx_data_o <= 8'h00;
         echo_q <= 7'h00;
      end else begin
         if (tx_load) begin
            tx_valid_o <= 1'b1;
            tx_data_o <= tx_char;
         end else if (tx_ready_i) begin
            tx_valid_o <= 1'b0;
         end
         if (!echo_on_i) echo_q <= 7'h00;
         else echo_q <= echo_q + {6'h00, tx_sent} - {6'h00, rx_echo};
      end
   end

   // Decimal field of return code and checksum lines
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         num_q <= 32'h0000_0000;
      end else if (rx_take && (state_q == S_CODE || state_q == S_SUM)) begin
         if (is_lf) num_q <= 32'h0000_0000;
         else if (is_digit) num_q <= dec_acc(num_q, c);
      end else if (state_q == S_IDLE) begin
         num_q <= 32'h0000_0000;
      end
   end

   // Line decode, group counting, checksum and retransmit bookkeeping
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         col_q <= 7'h00;
         left_q <= 6'h00;
         quad_q <= 2'h0;
         acc_q <= 18'h0_0000;
         lines_q <= 5'h00;
         sum_q <= 32'h0000_0000;
         bytes_q <= 32'h0000_0000;
         grp_q <= 32'h0000_0000;
         retransmit_request_q <= 1'b0;
         rep_q <= 4'h0;
      end else if (state_q == S_IDLE) begin
         col_q <= 7'h00;
         lines_q <= 5'h00;
         sum_q <= 32'h0000_0000;
         bytes_q <= 32'h0000_0000;
         grp_q <= 32'h0000_0000;
      end else if (state_q == S_LINE && rx_take) begin
         if (is_lf) begin
            col_q <= 7'h00;
            lines_q <= (state_d == S_SUM) ? 5'h00 : lines_q + 5'h01; // RL2
         end else begin
            col_q <= col_q + 7'h01;
            if (col_q == 7'h00) begin
               left_q <= uu6(c);
               quad_q <= 2'h0;
            end else begin
               quad_q <= quad_q + 2'h1;
               acc_q <= {acc_q[11:0], uu6(c)};
               if (quad_done) begin
                  left_q <= left_q - {4'h0, nb};
                  bytes_q <= bytes_q + {30'h0000_0000, nb};
                  sum_q <= sum_q + {24'h00_0000, word[23:16]} // RL3
                     + ((nb >= 2'h2) ? {24'h00_0000, word[15:8]} : 32'h0000_0000)
                     + ((nb == 2'h3) ? {24'h00_0000, word[7:0]} : 32'h0000_0000);
               end
            end
         end
      end else if (state_q == S_SUM && rx_take && is_lf) begin
         retransmit_request_q <= (num_q != sum_q);
         rep_q <= 4'h0;
         lines_q <= 5'h00;
         sum_q <= 32'h0000_0000; // RL3
         if (num_q != sum_q) bytes_q <= grp_q; // RL9
         else grp_q <= bytes_q;
      end else if (state_q == S_REPLY && tx_free) begin
         rep_q <= rep_q + 4'h1;
      end
   end

   // Data and result outputs
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         rd_valid_o <= 1'b0;
         rd_data_o <= 24'h00_0000;
         rd_count_o <= 2'h0;
         rd_offset_o <= 32'h0000_0000;
         rd_rewind_o <= 1'b0;
         done_o <= 1'b0;
         result_code_o <= 32'h0000_0000;
         result_local_o <= LOC_NONE;
      end else begin
         rd_valid_o <= quad_done && nb != 2'h0;
         if (quad_done) begin
            rd_data_o <= word;
            rd_count_o <= nb;
            rd_offset_o <= bytes_q;
         end
         rd_rewind_o <= state_q == S_SUM && rx_take && is_lf && num_q != sum_q;
         done_o <= finish;
         if (finish) begin
            result_code_o <= fin_code;
            result_local_o <= fin_local;
         end
      end
   end

   // Mirror of the device's prepared state; copy/erase is issued elsewhere
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         sectors_ready_o <= 1'b0;
      end else if (finish && !read_q && state_q == S_CODE && fin_code == CODE_SUCCESS) begin
         sectors_ready_o <= 1'b1; // RL15 RL17
      end else if (flash_op_done_i) begin
         sectors_ready_o <= 1'b0; // RL18
      end
   end

   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (rst_i);

   sequence s_sum_lf;
      state_q == S_SUM && rx_take && is_lf;
   endsequence

   a_tx_held: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
      else $error("tx byte dropped before accept");
   a_align_reject: assert property (state_q == S_IDLE && cmd_valid_i && cmd_read_i && addr_i[1:0] != 2'h0 // RL10
      |=> done_o && result_local_o == LOC_ALIGN && state_q == S_IDLE) else $error("misaligned read sent");
   a_count_reject: assert property (state_q == S_IDLE && cmd_valid_i && cmd_read_i && addr_i[1:0] == 2'h0 // RL11
      && count_i[1:0] != 2'h0 |=> done_o && result_local_o == LOC_COUNT) else $error("bad count sent");
   a_sector_order: assert property (state_q == S_IDLE && cmd_valid_i && !cmd_read_i // RL16
      && sec_last_i < sec_first_i |=> done_o && result_local_o == LOC_SECTOR) else $error("bad range sent");
   a_letter_first: assert property (state_q == S_LETTER && tx_free // RL14
      |=> tx_valid_o && tx_data_o == (read_q ? CH_READ : CH_PREP)) else $error("wrong command letter");
   a_group_bound: assert property (lines_q < GRP_LINES) // RL2
      else $error("group exceeded line count");
   a_ok_reply: assert property (s_sum_lf ##0 (num_q == sum_q) |=> state_q == S_REPLY && !retransmit_request_q && sum_q == 0 // RL7
      ##1 tx_valid_o && tx_data_o == CH_O) else $error("OK reply missing");
   a_retransmit_request_rewind: assert property (s_sum_lf ##0 (num_q != sum_q) |=> retransmit_request_q && bytes_q == grp_q // RL8 RL9
      && rd_rewind_o ##1 tx_data_o == CH_READ) else $error("retransmit_request reply or rewind missing");
   a_line_limit: assert property (state_q == S_LINE |-> col_q <= LINE_MAX_CHARS && left_q <= LINE_MAX_BYTES) // RL4
      else $error("encoded line too long");
   a_prep_clear: assert property (sectors_ready_o && flash_op_done_i && !finish |=> !sectors_ready_o) // RL18
      else $error("prepared state kept after flash op");
endmodule : sbh_host
`default_nettype wire

// [verification/sbh_dev_model.sv]
// Device-side model: answers read and prepare command lines.
// Assumes the host sends one line at a time and waits for the answer.
`timescale 1ns/100ps
`default_nettype none
module sbh_dev_model #(
   parameter logic [31:0] RAM_BASE = 32'h1000_0000,
   parameter logic [31:0] MEM_SIZE = 32'h0000_1000,
   parameter logic [31:0] BOOT_SEC = 32'h0000_0007,
   parameter int C_ALIGN = 21,
   parameter int C_COUNT = 22,
   parameter int C_PROT = 23,
   parameter int C_MAP = 24,
   parameter int C_SECT = 25,
   parameter int C_BUSY = 26
) (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic rst_i,
   // Serial byte channel
   input wire logic [7:0] tx_data_i,
   input wire logic tx_valid_i,
   output logic tx_ready_o,
   output logic [7:0] rx_data_o,
   output logic rx_valid_o,
   // Device conditions
   input wire logic echo_i,
   input wire logic prot_i,
   input wire logic bad_sum_i,
   input wire logic flash_busy_i
);
   logic [7:0] q[$];
   logic [31:0] n[2];
   int fld, f, off, g, lines, sum, bad;
   function automatic logic [7:0] memb(input logic [31:0] a);
      return a[7:0] ^ a[15:8] ^ 8'hA5;
   endfunction : memb
   // Half-rate stalls while echoing, prompt otherwise
   always @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) tx_ready_o <= 1'b0;
      else tx_ready_o <= #1 echo_i ? ~tx_ready_o : 1'b1;
   end
   task automatic put(input logic [7:0] b);
      @(posedge core_clk_i);
      #1 rx_data_o = b;
      rx_valid_o = 1'b1;
      @(posedge core_clk_i);
      #1 rx_valid_o = 1'b0;
      rx_data_o = ~b; // Idle line never repeats the last byte
   endtask : put
   task automatic put_dec(input int v);
      string s;
      s = $sformatf("%0d", v);
      foreach (s[i]) put(s[i]);
      put(8'h0D);
      put(8'h0A);
   endtask : put_dec
   task automatic get_line();
      q = {};
      do begin
         @(posedge core_clk_i);
         if (tx_valid_i && tx_ready_o) q.push_back(tx_data_i);
      end while (q.size() == 0 || q[$] != 8'h0A);
      if (echo_i) foreach (q[i]) put(q[i]);
   endtask : get_line
   task automatic put_line(input logic [31:0] a, input int cnt);
      logic [23:0] v;
      put(8'h20 + cnt[7:0]);
      for (int j = 0; j < cnt; j += 3) begin
         for (int k = 0; k < 3; k++) begin
            v[23-8*k -: 8] = (j + k < cnt) ? memb(a + j + k) : 8'h00;
            if (j + k < cnt) sum += memb(a + j + k);
         end
         for (int k = 0; k < 4; k++) put(v[23-6*k -: 6] == 0 ? 8'h60 : {2'b00, v[23-6*k -: 6]} + 8'h20);
      end
      put(8'h0D);
      put(8'h0A);
   endtask : put_line
   initial begin
      rx_valid_o = 1'b0;
      rx_data_o = 8'h00;
      @(negedge rst_i);
      forever begin
         get_line();
         fld = -1;
         n[0] = 0;
         n[1] = 0;
         foreach (q[i]) begin
            if (q[i] == 8'h20) fld++;
            else if (q[i] >= 8'h30 && q[i] <= 8'h39 && fld inside {0, 1}) n[fld] = n[fld] * 10 + q[i] - 8'h30;
         end
         if (q[0] == 8'h50) begin
            if (flash_busy_i) put_dec(C_BUSY);
            else if (n[0] > n[1] || (n[0] <= BOOT_SEC && BOOT_SEC <= n[1])) put_dec(C_SECT);
            else put_dec(0);
         end else if (prot_i) put_dec(C_PROT);
         else if (n[0][1:0] != 2'b00) put_dec(C_ALIGN);
         else if (n[1][1:0] != 2'b00) put_dec(C_COUNT);
         else if (!(n[0] < MEM_SIZE || (n[0] >= RAM_BASE && n[0] < RAM_BASE + MEM_SIZE))) put_dec(C_MAP);
         else begin
            put_dec(0);
            bad = bad_sum_i;
            off = 0;
            while (off < n[1]) begin
               g = off;
               sum = 0;
               lines = 0;
               while (lines < 20 && off < n[1]) begin
                  f = (n[1] - off > 45) ? 45 : n[1] - off;
                  put_line(n[0] + off, f);
                  off += f;
                  lines++;
               end
               put_dec(sum + bad);
               bad = 0;
               get_line();
               if (q[0] == 8'h52) off = g;
            end
         end
      end
   end
endmodule : sbh_dev_model
`default_nettype wire

// [verification/testbench.sv]
// Self-checking bench for the serial boot host controller.
// Assumes the device model sits on the byte channel.
`timescale 1ns/100ps
`default_nettype none
module testbench;
   import sbh_pkg::*;
   localparam int LIMIT = 60000;
   localparam logic [31:0] RAM = 32'h1000_0000;
   localparam int C_PROT = 23;
   localparam int C_MAP = 24;
   localparam int C_SECT = 25;
   localparam int C_BUSY = 26;
   logic clk, rst, cv, crd, echo, fdone, prot, bad, fbusy, txv, txr, rxv;
   logic busy, done, rdv, rew, secr;
   logic [31:0] addr, cnt, code, roff;
   logic [7:0] sf, sl, txd, rxd;
   logic [2:0] loc;
   logic [23:0] rdd;
   logic [1:0] rdc;
   int miscompares, checks_done, cyc, hi, rewinds;
   sbh_host sbh_host_i (.core_clk_i(clk), .rst_i(rst), .cmd_valid_i(cv), .cmd_read_i(crd),
      .addr_i(addr), .count_i(cnt), .sec_first_i(sf), .sec_last_i(sl), .echo_on_i(echo),
      .flash_op_done_i(fdone), .tx_data_o(txd), .tx_valid_o(txv), .tx_ready_i(txr),
      .rx_data_i(rxd), .rx_valid_i(rxv), .busy_o(busy), .done_o(done), .result_code_o(code),
      .result_local_o(loc), .rd_data_o(rdd), .rd_count_o(rdc), .rd_offset_o(roff),
      .rd_valid_o(rdv), .rd_rewind_o(rew), .sectors_ready_o(secr));
   sbh_dev_model #(.C_PROT(C_PROT), .C_MAP(C_MAP), .C_SECT(C_SECT), .C_BUSY(C_BUSY)) sbh_dev_model_i (
      .core_clk_i(clk), .rst_i(rst), .tx_data_i(txd), .tx_valid_i(txv), .tx_ready_o(txr),
      .rx_data_o(rxd), .rx_valid_o(rxv), .echo_i(echo), .prot_i(prot), .bad_sum_i(bad),
      .flash_busy_i(fbusy));
   task automatic conclude();
      $display("Checks %0d, mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : conclude
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // Decoded bytes are judged against the model's fill pattern
   always @(posedge clk) begin
      cyc++;
      if (rew === 1'b1) rewinds++;
      if (rdv === 1'b1) begin
         for (int k = 0; k < 3; k++)
            if (k < rdc) chk({24'h0, rdd[23-8*k -: 8]}, {24'h0, 8'((addr + roff + k) ^ ((addr + roff + k) >> 8) ^ 8'hA5)});
         if (roff + rdc > hi) hi = roff + rdc;
      end
      if (cyc >= LIMIT) begin
         miscompares++;
         conclude();
      end
   end
   task automatic run(input logic rd, input logic [31:0] a, c, input logic [7:0] f, l,
                      input logic [31:0] ec, input logic [2:0] el);
      int w;
      hi = 0;
      rewinds = 0;
      w = 0;
      @(posedge clk);
      #1 cv = 1'b1;
      crd = rd;
      addr = a;
      cnt = c;
      sf = f;
      sl = l;
      @(posedge clk);
      #1 cv = 1'b0;
      while (done !== 1'b1 && w < LIMIT) begin
         @(posedge clk);
         #1;
         w++;
      end
      chk(code, ec);
      chk({29'h0, loc}, {29'h0, el});
   endtask : run
   task automatic t_echo_read();
      run(1'b1, RAM, 4, 0, 0, 0, 0);
      chk(hi, 4);
      repeat (60) @(posedge clk);
      #1 echo = 1'b0;
      $display("test echo_read done");
   endtask : t_echo_read
   task automatic t_long();
      run(1'b1, 0, 908, 0, 0, 0, 0);
      chk(hi, 908);
      chk(rewinds, 0);
      $display("test long done");
   endtask : t_long
   task automatic t_retransmit_request();
      bad = 1'b1;
      run(1'b1, RAM + 8, 96, 0, 0, 0, 0);
      bad = 1'b0;
      chk(rewinds, 1);
      chk(hi, 96);
      $display("test retransmit_request done");
   endtask : t_retransmit_request
   task automatic t_reject();
      prot = 1'b1;
      run(1'b1, RAM, 4, 0, 0, C_PROT, 0);
      prot = 1'b0;
      run(1'b1, 32'h2000_0000, 4, 0, 0, C_MAP, 0);
      run(1'b1, RAM + 2, 4, 0, 0, 0, 1);
      run(1'b1, RAM, 6, 0, 0, 0, 2);
      chk(hi, 0);
      $display("test reject done");
   endtask : t_reject
   task automatic t_prepare();
      run(1'b0, 0, 0, 0, 0, 0, 0);
      chk(secr, 1);
      @(posedge clk);
      #1 fdone = 1'b1;
      @(posedge clk);
      #1 fdone = 1'b0;
      chk(secr, 0);
      run(1'b0, 0, 0, 3, 9, C_SECT, 0);
      chk(secr, 0);
      fbusy = 1'b1;
      run(1'b0, 0, 0, 1, 2, C_BUSY, 0);
      fbusy = 1'b0;
      run(1'b0, 0, 0, 5, 3, 0, 3);
      $display("test prepare done");
   endtask : t_prepare
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   initial begin
      {cv, crd, fdone, prot, bad, fbusy} = 6'h00;
      echo = 1'b1;
      addr = 0;
      cnt = 0;
      sf = 0;
      sl = 0;
      miscompares = 0;
      checks_done = 0;
      cyc = 0;
      rst = 1'b1;
      repeat (8) @(posedge clk);
      #1 rst = 1'b0;
      t_echo_read();
      t_long();
      t_retransmit_request();
      t_reject();
      t_prepare();
      conclude();
   end
endmodule : testbench
`default_nettype wire
